/* rtl/cmm_mmu.sv */
// Function
// - The core runs in one of five modes, three of which form a super-privileged group.
// - Every reset starts the core in boot mode, and no later request can return to it.
// - An exception cannot be masked, vectors to a fixed per-source address and enters system.
// - Breakpoint, fault, illegal op, stack overflow, bad syscall and user return raise one.
// - Virtual addresses map to RAM, ROM and EEPROM by a fixed partition and user segments.
// - Up to 64 segments serve user code and each may lie in RAM, ROM or EEPROM.
// - Each segment has position, size, enable, read, write, execute and register rights.
// - The descriptor table lies at a fixed register offset and also holds user register rights; the base register is only stored.
// - System mode has free access in the partition; every mode but user may write the configuration.
// - Every user access is checked and user register access follows the segment rights.
// - Test mode can be locked for good, and test-only registers open only in test mode.
// - Contactless mode runs support firmware and application software cannot enter it.
// - The top 128 bytes of EEPROM are kept for configuration and life-cycle data.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cmm_mmu #(
  parameter int NSEG = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cmm_pkg::cmm_mreq_t mode_req,
  input wire logic [cmm_pkg::EXC_NUM-1:0] exc_src,
  input wire logic return_from_interrupt_instruction,
  input wire logic test_fuse_blown,
  input wire cmm_pkg::cmm_acc_t acc,
  output cmm_pkg::cmm_rsp_t rsp,
  output cmm_pkg::cmm_mode_t cpu_mode,
  output logic exc_valid,
  output logic [15:0] exc_vector,
  output logic irq
);

  localparam int SW = 6;

  // Segment entries are decoded with a six-bit index, so more than 64 cannot be served.
  if (NSEG < 1 || NSEG > 64) begin : g_bad_nseg
    $error("NSEG must lie between 1 and 64");
  end

  typedef struct packed {
    cmm_pkg::cmm_mode_t mode;
    logic test_lock;
    logic [15:0] tbase;
    logic [cmm_pkg::IRQ_W-1:0] sts;
    logic [cmm_pkg::IRQ_W-1:0] ien;
    logic [15:0] fault;
    logic [SW-1:0] cur_seg;
    logic awg;
    logic [11:0] awa;
    logic wg;
    logic [31:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    cmm_pkg::cmm_rsp_t rsp;
    logic exc_v;
    logic [15:0] exc_vec;
    cmm_pkg::cmm_seg_t [NSEG-1:0] seg;
  } cmm_state_t;

  cmm_state_t s_q;
  cmm_state_t s_d;

  logic [NSEG-1:0] hit;
  logic [NSEG-1:0][15:0] offs;

  // Each segment compares the address in parallel; size zero never hits.
  genvar gi;
  generate
    for (gi = 0; gi < NSEG; gi++) begin : g_seg
      assign offs[gi] = acc.addr - s_q.seg[gi].base;
      assign hit[gi] = s_q.seg[gi].en && (acc.addr >= s_q.seg[gi].base) &&
                       ({1'b0, offs[gi]} < {1'b0, s_q.seg[gi].size});
    end
  endgenerate

  // Fixed partition for the privileged modes.
  logic [1:0] part_region;
  logic [15:0] part_phys;
  always_comb begin
    if (acc.addr >= cmm_pkg::PART_EE_BASE) begin
      part_region = cmm_pkg::REG_EE;
      part_phys = acc.addr - cmm_pkg::PART_EE_BASE;
    end else if (acc.addr >= cmm_pkg::PART_ROM_BASE) begin
      part_region = cmm_pkg::REG_ROM;
      part_phys = acc.addr - cmm_pkg::PART_ROM_BASE;
    end else begin
      part_region = cmm_pkg::REG_RAM;
      part_phys = acc.addr;
    end
  end

  // Bus handshakes are combinational from the holding flags.
  assign s_axi_awready = !s_q.awg && !s_q.bv;
  assign s_axi_wready = !s_q.wg && !s_q.bv;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = s_q.br;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd;
  assign s_axi_rresp = s_q.rr;
  assign rsp = s_q.rsp;
  assign cpu_mode = s_q.mode;
  assign exc_valid = s_q.exc_v;
  assign exc_vector = s_q.exc_vec;
  assign irq = |(s_q.sts & s_q.ien);

  always_comb begin
    logic [cmm_pkg::EXC_NUM-1:0] exc;
    logic [cmm_pkg::IRQ_W-1:0] set;
    logic [cmm_pkg::IRQ_W-1:0] clr;
    logic found;
    logic [SW-1:0] sidx;
    logic perm;
    logic ok;
    logic [15:0] ph;
    logic [1:0] rg;
    logic cfg_ok;
    logic [11:0] wa;
    logic [SW-1:0] widx;
    cmm_pkg::cmm_seg_t cs;
    exc = exc_src;
    set = '0;
    clr = '0;
    found = 1'b0;
    sidx = '0;
    perm = 1'b0;
    ok = 1'b0;
    ph = part_phys;
    rg = part_region;
    cfg_ok = 1'b0;
    wa = '0;
    widx = '0;
    cs = s_q.seg[s_q.cur_seg];
    s_d = s_q;
    s_d.exc_v = 1'b0;
    s_d.rsp.valid = 1'b0;

    // Fuse closes test mode for good; the register lock holds until the next reset.
    if (test_fuse_blown) begin
      s_d.test_lock = 1'b1;
    end

    // A return from interrupt is only legal in the privileged modes.
    exc[cmm_pkg::EXC_RTI] = exc_src[cmm_pkg::EXC_RTI] ||
      (return_from_interrupt_instruction && s_q.mode == cmm_pkg::CMM_USER);

    // Mode requests: boot is never a target; test and contactless only leave boot.
    if (mode_req.valid) begin
      case (s_q.mode)
        cmm_pkg::CMM_BOOT: begin
          if (mode_req.target == cmm_pkg::CMM_SYSTEM ||
              mode_req.target == cmm_pkg::CMM_CLESS ||
              (mode_req.target == cmm_pkg::CMM_TEST && !s_q.test_lock)) begin
            s_d.mode = mode_req.target;
          end else begin
            set[cmm_pkg::IRQ_MODE] = 1'b1;
          end
        end
        cmm_pkg::CMM_TEST, cmm_pkg::CMM_CLESS: begin
          if (mode_req.target == cmm_pkg::CMM_SYSTEM) begin
            s_d.mode = cmm_pkg::CMM_SYSTEM;
          end else begin
            set[cmm_pkg::IRQ_MODE] = 1'b1;
          end
        end
        cmm_pkg::CMM_SYSTEM: begin
          if (mode_req.target == cmm_pkg::CMM_USER) begin
            s_d.mode = cmm_pkg::CMM_USER;
          end else begin
            set[cmm_pkg::IRQ_MODE] = 1'b1;
          end
        end
        default: begin
          set[cmm_pkg::IRQ_MODE] = 1'b1;
        end
      endcase
    end

    // Exceptions win over mode requests; lowest source index takes the vector.
    if (|exc) begin
      for (int i = cmm_pkg::EXC_NUM - 1; i >= 0; i--) begin
        if (exc[i]) begin
          s_d.exc_vec = cmm_pkg::EXC_VEC_BASE + 16'(i << cmm_pkg::EXC_VEC_SHIFT);
        end
      end
      s_d.exc_v = 1'b1;
      s_d.mode = cmm_pkg::CMM_SYSTEM;
      set[cmm_pkg::IRQ_EXC] = 1'b1;
    end

    // Lowest enabled segment that covers the address is used.
    for (int i = NSEG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        found = 1'b1;
        sidx = SW'(i);
      end
    end

    // Access check, answered one cycle after the request.
    if (acc.periph) begin
      if (acc.pid == cmm_pkg::PID_TEST) begin
        ok = (s_q.mode == cmm_pkg::CMM_TEST);
      end else if (s_q.mode == cmm_pkg::CMM_USER) begin
        ok = cs.en && cs.rights[acc.pid];
      end else begin
        ok = 1'b1;
      end
      ph = {13'h0, acc.pid};
      rg = '0;
    end else if (s_q.mode == cmm_pkg::CMM_USER) begin
      case (acc.kind)
        cmm_pkg::KIND_READ: perm = s_q.seg[sidx].r;
        cmm_pkg::KIND_WRITE: perm = s_q.seg[sidx].w;
        cmm_pkg::KIND_FETCH: perm = s_q.seg[sidx].x;
        default: perm = 1'b0;
      endcase
      ph = s_q.seg[sidx].phys + offs[sidx];
      rg = s_q.seg[sidx].region;
      ok = found && perm && !(rg == cmm_pkg::REG_EE && ph >= cmm_pkg::EE_ROW_BASE);
    end else begin
      ok = 1'b1;
    end
    if (acc.valid) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.ok = ok;
      s_d.rsp.phys = ph;
      s_d.rsp.region = rg;
      if (ok && !acc.periph && acc.kind == cmm_pkg::KIND_FETCH &&
          s_q.mode == cmm_pkg::CMM_USER) begin
        s_d.cur_seg = sidx;
      end
      if (!ok) begin
        set[cmm_pkg::IRQ_BLOCK] = 1'b1;
        s_d.fault = acc.addr;
      end
    end

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awg = 1'b1;
      s_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wg = 1'b1;
      s_d.wd = s_axi_wdata;
    end
    // Configuration is only writable outside user mode, so user code cannot lift its limits.
    cfg_ok = (s_q.mode != cmm_pkg::CMM_USER);
    if (s_q.awg && s_q.wg) begin
      wa = s_q.awa;
      widx = SW'(wa[9:3]);
      s_d.awg = 1'b0;
      s_d.wg = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = cmm_pkg::RESP_OKAY;
      if (wa == cmm_pkg::OFS_CTRL && cfg_ok) begin
        if (s_q.wd[cmm_pkg::CTRL_TEST_LOCK]) begin
          s_d.test_lock = 1'b1;
        end
      end else if (wa == cmm_pkg::OFS_TBASE && cfg_ok) begin
        s_d.tbase = s_q.wd[15:0];
      end else if (wa == cmm_pkg::OFS_IRQ_CLR) begin
        clr = s_q.wd[cmm_pkg::IRQ_W-1:0];
      end else if (wa == cmm_pkg::OFS_IRQ_EN) begin
        s_d.ien = s_q.wd[cmm_pkg::IRQ_W-1:0];
      end else if (wa >= cmm_pkg::OFS_SEG && wa[11:10] == cmm_pkg::OFS_SEG[11:10] &&
                   int'(wa[9:3]) < NSEG && cfg_ok) begin
        if (wa[2]) begin
          s_d.seg[widx][63:32] = s_q.wd;
        end else begin
          s_d.seg[widx][31:0] = s_q.wd;
        end
      end else begin
        s_d.br = cmm_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
    end

    // Read channel answers one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rv = 1'b1;
      s_d.rr = cmm_pkg::RESP_OKAY;
      s_d.rd = '0;
      if (s_axi_araddr == cmm_pkg::OFS_MODE) begin
        s_d.rd = {27'h0, s_q.test_lock, 1'b0, s_q.mode};
      end else if (s_axi_araddr == cmm_pkg::OFS_CTRL) begin
        s_d.rd = {31'h0, s_q.test_lock};
      end else if (s_axi_araddr == cmm_pkg::OFS_TBASE) begin
        s_d.rd = {16'h0000, s_q.tbase};
      end else if (s_axi_araddr == cmm_pkg::OFS_IRQ_STS) begin
        s_d.rd = {29'h0, s_q.sts};
      end else if (s_axi_araddr == cmm_pkg::OFS_IRQ_EN) begin
        s_d.rd = {29'h0, s_q.ien};
      end else if (s_axi_araddr == cmm_pkg::OFS_FAULT) begin
        s_d.rd = {16'h0000, s_q.fault};
      end else if (s_axi_araddr[11:10] == cmm_pkg::OFS_SEG[11:10] &&
                   int'(s_axi_araddr[9:3]) < NSEG) begin
        s_d.rd = s_axi_araddr[2] ? s_q.seg[SW'(s_axi_araddr[9:3])][63:32]
                                 : s_q.seg[SW'(s_axi_araddr[9:3])][31:0];
      end else begin
        s_d.rr = cmm_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
    end

    // A new event outlives a clear written in the same cycle.
    s_d.sts = (s_q.sts & ~clr) | set;
  end

  // Reset places the core in boot mode with all segments disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= cmm_pkg::CMM_BOOT;
      s_q.tbase <= cmm_pkg::TBASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : cmm_mmu

`default_nettype wire

/* rtl/cmm_pkg.sv */
package cmm_pkg;

  // CPU privilege modes; boot, test and contactless form the super-privileged group.
  typedef enum logic [2:0] {
    CMM_BOOT,
    CMM_TEST,
    CMM_CLESS,
    CMM_SYSTEM,
    CMM_USER
  } cmm_mode_t;

  // Access kinds issued by the core.
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_FETCH = 2'h2;

  // Physical regions.
  localparam logic [1:0] REG_RAM = 2'h0;
  localparam logic [1:0] REG_ROM = 2'h1;
  localparam logic [1:0] REG_EE = 2'h2;

  // Fixed partition of the virtual space used outside user mode.
  localparam logic [15:0] PART_ROM_BASE = 16'h2000;
  localparam logic [15:0] PART_EE_BASE = 16'hC000;
  // EEPROM size and its reserved top row of 128 bytes.
  localparam logic [15:0] EE_SIZE = 16'h4000;
  localparam logic [15:0] EE_ROW_BYTES = 16'h0080;
  localparam logic [15:0] EE_ROW_BASE = EE_SIZE - EE_ROW_BYTES;

  // Peripheral group reserved for test-only registers.
  localparam logic [2:0] PID_TEST = 3'h7;

  // Exception sources and vectors.
  localparam int EXC_NUM = 6;
  localparam int EXC_BRK = 0;
  localparam int EXC_FAULT = 1;
  localparam int EXC_ILLEGAL = 2;
  localparam int EXC_STACK = 3;
  localparam int EXC_SYSCALL = 4;
  localparam int EXC_RTI = 5;
  localparam logic [15:0] EXC_VEC_BASE = 16'h0010;
  localparam int EXC_VEC_SHIFT = 3;

  // Register byte offsets.
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_TBASE = 12'h008;
  localparam logic [11:0] OFS_IRQ_STS = 12'h00C;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN = 12'h014;
  localparam logic [11:0] OFS_FAULT = 12'h018;
  localparam logic [11:0] OFS_SEG = 12'h400;
  localparam int SEG_STRIDE_SHIFT = 3;
  localparam int CTRL_TEST_LOCK = 0;

  // Interrupt status bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_EXC = 0;
  localparam int IRQ_BLOCK = 1;
  localparam int IRQ_MODE = 2;

  // Reset values.
  localparam logic [15:0] TBASE_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Segment descriptor: word 0 is {size, base}, word 1 is {phys, rights, 2'b0, region, x, w, r, en}.
  typedef struct packed {
    logic [15:0] phys;
    logic [7:0] rights;
    logic [1:0] rsvd;
    logic [1:0] region;
    logic x;
    logic w;
    logic r;
    logic en;
    logic [15:0] size;
    logic [15:0] base;
  } cmm_seg_t;

  // Access request from the core.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [1:0] kind;
    logic periph;
    logic [2:0] pid;
  } cmm_acc_t;

  // Registered answer to the memories and registers.
  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] phys;
    logic [1:0] region;
  } cmm_rsp_t;

  // Mode change request from the core.
  typedef struct packed {
    logic valid;
    cmm_mode_t target;
  } cmm_mreq_t;

endpackage : cmm_pkg

/* verif/cmm_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the core-facing ports; bus behaviour is judged by the bench.
module cmm_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire cmm_pkg::cmm_acc_t acc,
  input wire cmm_pkg::cmm_rsp_t rsp,
  input wire cmm_pkg::cmm_mreq_t mode_req,
  input wire logic [cmm_pkg::EXC_NUM-1:0] exc_src,
  input wire logic return_from_interrupt_instruction,
  input wire logic test_fuse_blown,
  input wire cmm_pkg::cmm_mode_t cpu_mode,
  input wire logic exc_valid,
  input wire logic [15:0] exc_vector
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Mode changes: boot only at reset, user only from system, contactless only from boot, test not while the fuse is blown.
  property p_boot;
    $rose(aresetn) |-> cpu_mode == cmm_pkg::CMM_BOOT;
  endproperty
  a_boot: assert property (p_boot) else $error("mode not boot after reset");
  property p_stay;
    cpu_mode != cmm_pkg::CMM_BOOT |=> cpu_mode != cmm_pkg::CMM_BOOT;
  endproperty
  a_stay: assert property (p_stay) else $error("boot mode re-entered");
  property p_user;
    $changed(cpu_mode) && cpu_mode == cmm_pkg::CMM_USER |-> $past(cpu_mode) == cmm_pkg::CMM_SYSTEM;
  endproperty
  a_user: assert property (p_user) else $error("user entered not from system");
  property p_cless;
    $changed(cpu_mode) && cpu_mode == cmm_pkg::CMM_CLESS |-> $past(cpu_mode) == cmm_pkg::CMM_BOOT;
  endproperty
  a_cless: assert property (p_cless) else $error("contactless entered not from boot");
  property p_lock;
    mode_req.valid && mode_req.target == cmm_pkg::CMM_TEST && cpu_mode != cmm_pkg::CMM_TEST &&
      $past(test_fuse_blown) && $past(aresetn) |=> cpu_mode != cmm_pkg::CMM_TEST;
  endproperty
  a_lock: assert property (p_lock) else $error("test mode entered while locked");

  // Exceptions cannot be masked and always land in system mode.
  property p_exc;
    |exc_src |=> exc_valid && cpu_mode == cmm_pkg::CMM_SYSTEM;
  endproperty
  a_exc: assert property (p_exc) else $error("exception not taken");
  property p_brk;
    exc_src[0] |=> exc_vector == 16'h0010;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint vector wrong");
  property p_rti;
    return_from_interrupt_instruction && cpu_mode == cmm_pkg::CMM_USER && exc_src == '0
      |=> exc_valid && exc_vector == 16'h0038;
  endproperty
  a_rti: assert property (p_rti) else $error("user return not trapped");

  // Every access gets exactly one answer one cycle later.
  property p_rsp;
    1'b1 |=> rsp.valid == $past(acc.valid);
  endproperty
  a_rsp: assert property (p_rsp) else $error("access answer timing wrong");

  c_block: cover property (rsp.valid && !rsp.ok && cpu_mode == cmm_pkg::CMM_USER);
  c_exc: cover property (exc_valid);
  c_test: cover property (cpu_mode == cmm_pkg::CMM_TEST);
endmodule : cmm_chk

bind cmm_mmu cmm_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .acc(acc), .rsp(rsp), .mode_req(mode_req),
  .exc_src(exc_src), .return_from_interrupt_instruction(return_from_interrupt_instruction),
  .test_fuse_blown(test_fuse_blown), .cpu_mode(cpu_mode), .exc_valid(exc_valid),
  .exc_vector(exc_vector)
);
`default_nettype wire

/* verif/cmm_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
// Core model: each call drives one request after an edge and drops it a cycle later.
module cmm_cpu (
  input wire logic aclk,
  input wire cmm_pkg::cmm_rsp_t rsp,
  output cmm_pkg::cmm_acc_t acc,
  output cmm_pkg::cmm_mreq_t mode_req,
  output logic [5:0] exc_src,
  output logic rti
);
  initial begin
    acc = '0;
    mode_req = '0;
    exc_src = '0;
    rti = 1'b0;
  end

  // A released request shows an inverted address, so a stale value never matches.
  task automatic access(input logic [15:0] a, input logic [1:0] k, input logic p,
                        input logic [2:0] id, output cmm_pkg::cmm_rsp_t r);
    @(posedge aclk);
    acc <= {1'b1, a, k, p, id};
    @(posedge aclk);
    acc <= {1'b0, ~a, k, p, id};
    #1;
    r = rsp;
  endtask : access

  // Mode request, exception sources and return instruction pulse together.
  task automatic pulse(input logic mv, input cmm_pkg::cmm_mode_t t, input logic [5:0] e,
                       input logic ri);
    @(posedge aclk);
    mode_req <= {mv, t};
    exc_src <= e;
    rti <= ri;
    @(posedge aclk);
    mode_req <= '0;
    exc_src <= '0;
    rti <= 1'b0;
    #1;
  endtask : pulse
endmodule : cmm_cpu
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  logic aclk, aresetn, fuse, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, excv, irq, rti;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [5:0] exc;
  logic [15:0] vec;
  cmm_pkg::cmm_acc_t acc;
  cmm_pkg::cmm_rsp_t rsp, q;
  cmm_pkg::cmm_mreq_t mreq;
  cmm_pkg::cmm_mode_t mode;
  int mismatches, comparisons;

  cmm_mmu u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_req(mreq), .exc_src(exc), .return_from_interrupt_instruction(rti),
    .test_fuse_blown(fuse), .acc(acc), .rsp(rsp), .cpu_mode(mode), .exc_valid(excv),
    .exc_vector(vec), .irq(irq)
  );
  cmm_cpu u_cpu (
    .aclk(aclk), .rsp(rsp), .acc(acc), .mode_req(mreq), .exc_src(exc), .rti(rti)
  );

  // Free-running 125 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic tmo(input logic ok);
    if (!ok) begin
      mismatches++;
      print_verdict();
    end
  endtask : tmo

  task automatic rst(input logic f);
    @(posedge aclk);
    aresetn <= 1'b0;
    fuse <= f;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  // Ready is judged at the falling edge, where it is settled, then acted on at the rise.
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic ta, tw, done;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    tmo(done);
    `CK(r, er)
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, done;
    logic [1:0] r;
    logic [31:0] d;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    tmo(done);
    `CK({r, d}, {er, ed})
    #1;
  endtask : rd

  // Phys and region are only meaningful when the access is allowed.
  task automatic ck_rsp(input logic ok, input logic [15:0] ph, input logic [1:0] rg);
    `CK({q.valid, q.ok}, {1'b1, ok})
    if (ok) `CK({q.phys, q.region}, {ph, rg})
  endtask : ck_rsp

  task automatic ac(input logic [15:0] a, input logic [1:0] k, input logic ok,
                    input logic [15:0] ph, input logic [1:0] rg);
    u_cpu.access(a, k, 1'b0, 3'h0, q);
    ck_rsp(ok, ph, rg);
  endtask : ac

  task automatic pc(input logic [2:0] id, input logic ok);
    u_cpu.access(16'h0000, 2'h0, 1'b1, id, q);
    ck_rsp(ok, {13'h0, id}, 2'h0);
  endtask : pc

  task automatic md(input cmm_pkg::cmm_mode_t t, input cmm_pkg::cmm_mode_t em);
    u_cpu.pulse(1'b1, t, 6'h00, 1'b0);
    `CK(mode, em)
  endtask : md

  task automatic ex(input logic [5:0] e, input logic ri, input logic ev, input logic [15:0] v);
    u_cpu.pulse(1'b0, cmm_pkg::CMM_BOOT, e, ri);
    `CK({excv, vec}, {ev, v})
    if (ev) `CK(mode, cmm_pkg::CMM_SYSTEM)
  endtask : ex

  // Main sequence: boot, test, system setup, user checks, exceptions, locked restart.
  initial begin
    aresetn = 1'b0;
    fuse = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    comparisons = 0;
    rst(1'b0);
    `CK(mode, cmm_pkg::CMM_BOOT)
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h0FC, 32'h0, 2'h2);
    wr(12'h000, 32'h7, 2'h2);
    ac(16'h0100, 2'h0, 1'b1, 16'h0100, 2'h0);
    ac(16'h2010, 2'h2, 1'b1, 16'h0010, 2'h1);
    ac(16'hC005, 2'h1, 1'b1, 16'h0005, 2'h2);
    md(cmm_pkg::CMM_TEST, cmm_pkg::CMM_TEST);
    pc(3'h7, 1'b1);
    md(cmm_pkg::CMM_SYSTEM, cmm_pkg::CMM_SYSTEM);
    pc(3'h7, 1'b0);
    ac(16'hFF00, 2'h1, 1'b1, 16'h3F00, 2'h2);
    md(cmm_pkg::CMM_CLESS, cmm_pkg::CMM_SYSTEM);
    wr(12'h008, 32'h1234, 2'h0);
    rd(12'h008, 32'h1234, 2'h0);
    wr(12'h004, 32'h1, 2'h0);
    rd(12'h004, 32'h1, 2'h0);
    wr(12'h400, 32'h01001000, 2'h0);
    wr(12'h404, 32'h0200080B, 2'h0);
    wr(12'h408, 32'h01003000, 2'h0);
    wr(12'h40C, 32'h3F000027, 2'h0);
    rd(12'h404, 32'h0200080B, 2'h0);
    wr(12'h014, 32'h7, 2'h0);
    md(cmm_pkg::CMM_USER, cmm_pkg::CMM_USER);
    ac(16'h1010, 2'h2, 1'b1, 16'h0210, 2'h0);
    ac(16'h1020, 2'h0, 1'b1, 16'h0220, 2'h0);
    ac(16'h1020, 2'h1, 1'b0, 16'h0, 2'h0);
    ac(16'h2000, 2'h0, 1'b0, 16'h0, 2'h0);
    pc(3'h3, 1'b1);
    pc(3'h2, 1'b0);
    ac(16'h3070, 2'h0, 1'b1, 16'h3F70, 2'h2);
    ac(16'h3080, 2'h0, 1'b0, 16'h0, 2'h0);
    `CK(irq, 1'b1)
    rd(12'h018, 32'h3080, 2'h0);
    wr(12'h008, 32'h5555, 2'h2);
    rd(12'h008, 32'h1234, 2'h0);
    md(cmm_pkg::CMM_BOOT, cmm_pkg::CMM_USER);
    rd(12'h00C, 32'h6, 2'h0);
    wr(12'h010, 32'h7, 2'h0);
    rd(12'h00C, 32'h0, 2'h0);
    `CK(irq, 1'b0)
    ex(6'h00, 1'b1, 1'b1, 16'h0038);
    ex(6'h00, 1'b1, 1'b0, 16'h0038);
    for (int i = 0; i < 6; i++) begin
      ex(6'(1 << i), 1'b0, 1'b1, 16'(16'h0010 + 8 * i));
    end
    ex(6'h14, 1'b0, 1'b1, 16'h0020);
    wr(12'h014, 32'h0, 2'h0);
    `CK(irq, 1'b0)
    wr(12'h014, 32'h1, 2'h0);
    `CK(irq, 1'b1)
    wr(12'h010, 32'h1, 2'h0);
    `CK(irq, 1'b0)
    rst(1'b1);
    `CK(mode, cmm_pkg::CMM_BOOT)
    rd(12'h000, 32'h10, 2'h0);
    md(cmm_pkg::CMM_TEST, cmm_pkg::CMM_BOOT);
    md(cmm_pkg::CMM_CLESS, cmm_pkg::CMM_CLESS);
    md(cmm_pkg::CMM_SYSTEM, cmm_pkg::CMM_SYSTEM);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
